/* File: rtl/mbws_regs.svh */
/*
 constants of the module bus wake-up slave: timing, character format, packet sizes.
 assumes one 100 MHz clock; included by bare name.
*/
`ifndef MBWS_REGS_SVH
`define MBWS_REGS_SVH
`define MBWS_CLK_HZ        100000000
`define MBWS_BAUD          500000
`define MBWS_BIT_CYCLES    (`MBWS_CLK_HZ / `MBWS_BAUD)
`define MBWS_HALF_CYCLES   (`MBWS_BIT_CYCLES / 2)
`define MBWS_CHAR_BITS     9
`define MBWS_FRAME_BITS    11
`define MBWS_ADDR_BIT      8
`define MBWS_CRC_INIT      16'hFFFF
`define MBWS_CRC_POLY      16'h1021
`define MBWS_CRC_GOOD      16'h0000
`define MBWS_FIFO_DEPTH    8
`define MBWS_LEN_W         8
`endif

/* File: rtl/mbws_pkg.sv */
/*
 types of the module bus wake-up slave.
 assumes mbws_regs.svh is on the include path.
*/
`include "mbws_regs.svh"
package mbws_pkg;
    typedef logic [7:0] mbws_byte_t;
    typedef logic [`MBWS_LEN_W-1:0] mbws_len_t;
    typedef enum logic [2:0] {
        MBWS_WAKE, MBWS_RECV, MBWS_CHECK, MBWS_SEND, MBWS_DRAIN
    } mbws_state_t;
endpackage

/* File: rtl/mbws_stream_if.sv */
/*
 valid/ready byte stream between the slave and its FIFO.
 assumes one clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
interface mbws_stream_if;
    logic [7:0] data;
    logic       valid;
    logic       ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

/* File: rtl/mbws_fifo.sv */
/*
 flip-flop FIFO with valid/ready on both sides.
 assumes synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module mbws_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             flush,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;
    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    always_ff @(posedge clock) begin
        if (push) mem[wr_ptr] <= in_data;
    end
    always_ff @(posedge clock) begin
        if (rst || flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            if (pop) rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

/* File: rtl/mbws_slave.sv */
/*
 module bus address wake-up slave: 9-bit serial receiver with address
 wake-up, CRC check of the poll, response sender and line driver enable.
 assumes rx line synchronous to clock; response loaded before the poll.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mbws_regs.svh"
// Behaviour
// - 500 kbaud, 9-bit characters, bit 9 marks address
// - wake-up mode drops characters without address mark
// - address character in wake-up or receive raises receive event
// - foreign address keeps wake-up mode
// - own address enters receive, buffers poll
// - CRC accumulated per poll data character in receive; own address restarts it
// - valid CRC: enable driver, send prepared response
// - after response: driver off, back to wake-up
// - driver enable low in send and drain: from valid CRC until the last stop bit, also while waiting for response
module mbws_slave (
    input  wire logic               clock,
    input  wire logic               rst,
    input  wire logic [7:0]         module_address,
    input  wire mbws_pkg::mbws_len_t poll_length,
    input  wire mbws_pkg::mbws_byte_t resp_data,
    input  wire logic               resp_valid,
    output logic                    resp_ready,
    input  wire logic               resp_last,
    input  wire logic               serial_port_rx,
    output logic                    serial_port_tx,
    output logic                    line_driver_enable_n,
    output logic                    address_event,
    output logic [7:0]              poll_data,
    output logic                    poll_valid,
    input  wire logic               poll_ready,
    output logic                    poll_done,
    output logic                    poll_crc_ok
);
    import mbws_pkg::*;

    mbws_state_t state;
    mbws_state_t next_state;
    mbws_stream_if rxs ();

    // receiver
    logic [15:0] rx_cnt;
    logic [3:0]  rx_bit;
    logic [9:0]  rx_shift;
    logic        rx_busy;
    logic        rx_done;
    logic        rx_prev;
    // half-bit preload puts every tick at mid-bit
    wire rx_tick  = rx_busy && (rx_cnt == 16'(`MBWS_BIT_CYCLES - 1));
    wire rx_start = !rx_busy && rx_prev && !serial_port_rx;
    always_ff @(posedge clock) begin
        rx_prev <= rst ? 1'b1 : serial_port_rx;
        rx_done <= 1'b0;
        if (rst) begin
            rx_busy <= 1'b0;
            rx_cnt <= 16'h0000;
            rx_bit <= 4'h0;
        end else if (rx_start) begin
            rx_busy <= 1'b1;
            rx_cnt <= 16'(`MBWS_HALF_CYCLES);
            rx_bit <= 4'h0;
        end else if (rx_tick) begin
            rx_cnt <= 16'h0000;
            rx_shift <= {serial_port_rx, rx_shift[9:1]};
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == 4'(`MBWS_CHAR_BITS)) begin
                rx_busy <= 1'b0;
                rx_done <= 1'b1;
            end
        end else if (rx_busy) begin
            rx_cnt <= rx_cnt + 16'h0001;
        end
    end
    // after ten samples the start bit sits in bit 0; data in 9:1
    wire [8:0] rx_char   = rx_shift[9:1];
    wire       rx_is_adr = rx_char[`MBWS_ADDR_BIT];
    wire [7:0] rx_byte   = rx_char[7:0];

    // crc over received poll characters
    logic [15:0] crc;
    logic [15:0] crc_calc;
    // one polynomial step per data bit, msb first
    logic [15:0] crc_step [9];
    assign crc_step[0] = crc ^ {rx_byte, 8'h00};
    for (genvar g = 0; g < 8; g++) begin : g_crc
        assign crc_step[g+1] = crc_step[g][15]
            ? ((crc_step[g] << 1) ^ `MBWS_CRC_POLY) : (crc_step[g] << 1);
    end
    assign crc_calc = crc_step[8];
    mbws_len_t rx_count;
    // an address mark is judged in wake-up and also mid-poll, where own address restarts and a foreign one returns to wake-up
    wire in_listen = (state == MBWS_WAKE) || (state == MBWS_RECV);
    wire adr_hit   = in_listen && rx_done && rx_is_adr;
    wire own_adr   = adr_hit && (rx_byte == module_address);
    wire poll_char = (state == MBWS_RECV) && rx_done && !rx_is_adr;
    wire poll_end  = poll_char && (rx_count == poll_length - `MBWS_LEN_W'(1));
    wire crc_good  = (crc == `MBWS_CRC_GOOD);

    // poll buffer
    // a full fifo drops the byte; the poll is still judged
    assign rxs.data  = rx_byte;
    assign rxs.valid = poll_char;
    mbws_fifo #(.WIDTH(8), .DEPTH(`MBWS_FIFO_DEPTH)) u_fifo (
        .clock     (clock),
        .rst       (rst),
        .flush     (own_adr),
        .in_data   (rxs.data),
        .in_valid  (rxs.valid),
        .in_ready  (rxs.ready),
        .out_data  (poll_data),
        .out_valid (poll_valid),
        .out_ready (poll_ready)
    );

    // transmitter
    logic [15:0] tx_cnt;
    logic [3:0]  tx_bit;
    logic [10:0] tx_shift;
    logic        tx_busy;
    wire tx_tick = tx_busy && (tx_cnt == 16'(`MBWS_BIT_CYCLES - 1));
    // a byte is loaded only on a granted handshake, so the source sees each take
    wire tx_load = resp_ready && resp_valid;
    wire tx_fin  = tx_tick && (tx_bit == 4'(`MBWS_FRAME_BITS - 1));

    always_comb begin
        next_state = state;
        unique case (state)
            MBWS_WAKE:  if (own_adr) next_state = MBWS_RECV;
            MBWS_RECV: begin
                if (adr_hit) next_state = own_adr ? MBWS_RECV : MBWS_WAKE;
                else if (poll_end) next_state = MBWS_CHECK;
            end
            MBWS_CHECK: next_state = crc_good ? MBWS_SEND : MBWS_WAKE;
            MBWS_SEND:  if (tx_load && resp_last) next_state = MBWS_DRAIN;
            // drain holds the driver until the last stop bit has left
            MBWS_DRAIN: if (!tx_busy) next_state = MBWS_WAKE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state <= MBWS_WAKE;
            crc <= `MBWS_CRC_INIT;
            rx_count <= '0;
        end else begin
            state <= next_state;
            if (own_adr) begin
                crc <= `MBWS_CRC_INIT;
                rx_count <= '0;
            end else if (poll_char) begin
                crc <= crc_calc;
                rx_count <= rx_count + `MBWS_LEN_W'(1);
            end
        end
    end

    // transmit shifter: one bit per baud period, ends after the stop bit
    always_ff @(posedge clock) begin
        if (rst) begin
            tx_busy <= 1'b0;
            tx_cnt <= 16'h0000;
            tx_bit <= 4'h0;
            tx_shift <= 11'h7FF;
        end else if (tx_load) begin
            tx_busy <= 1'b1;
            tx_cnt <= 16'h0000;
            tx_bit <= 4'h0;
            // start, 8 data lsb first, ninth bit clear, stop
            tx_shift <= {2'b10, resp_data, 1'b0};
        end else if (tx_tick) begin
            tx_cnt <= 16'h0000;
            tx_shift <= {1'b1, tx_shift[10:1]};
            tx_bit <= tx_bit + 4'h1;
            if (tx_fin) tx_busy <= 1'b0;
        end else if (tx_busy) begin
            tx_cnt <= tx_cnt + 16'h0001;
        end
    end

    // next values of the registered pins
    wire next_tx       = tx_busy ? tx_shift[0] : 1'b1;
    wire next_drive    = (next_state == MBWS_SEND) || (next_state == MBWS_DRAIN);
    wire tx_free_next  = !tx_busy || tx_fin;
    wire next_resp_rdy = (next_state == MBWS_SEND) && !tx_load && tx_free_next;
    wire judging       = (state == MBWS_CHECK);

    // line side: idle high, driver released
    always_ff @(posedge clock) begin
        if (rst) begin
            serial_port_tx <= 1'b1;
            line_driver_enable_n <= 1'b1;
        end else begin
            serial_port_tx <= next_tx;
            line_driver_enable_n <= !next_drive;
        end
    end

    // one-cycle status pulses
    always_ff @(posedge clock) begin
        if (rst) begin
            address_event <= 1'b0;
            poll_done <= 1'b0;
            poll_crc_ok <= 1'b0;
        end else begin
            address_event <= adr_hit;
            poll_done <= judging;
            poll_crc_ok <= judging && crc_good;
        end
    end

    // response handshake: ready is the load permission of the next cycle
    always_ff @(posedge clock) begin
        if (rst) resp_ready <= 1'b0;
        else resp_ready <= next_resp_rdy;
    end
endmodule
`default_nettype wire

/* File: test/mbws_host.sv */
/*
 host bus master model: sends 9-bit frames, collects reply frames.
 assumes mbws_regs.svh on the include path.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mbws_regs.svh"
module mbws_host (
    input  wire logic clock,
    output logic      rx,
    input  wire logic tx
);
    logic [8:0] got [$];
    initial rx = 1'b1;
    task automatic send_char(input logic [8:0] c);
        for (int i = 0; i < `MBWS_FRAME_BITS; i++) begin
            rx <= (i == 0) ? 1'b0 : (i > 9) ? 1'b1 : c[i-1];
            repeat (`MBWS_BIT_CYCLES) @(posedge clock);
        end
    endtask
    always begin : listen
        logic [8:0] c;
        @(posedge clock iff tx === 1'b0);
        repeat (`MBWS_HALF_CYCLES) @(posedge clock);
        for (int i = 0; i < 10; i++) begin
            repeat (`MBWS_BIT_CYCLES) @(posedge clock);
            if (i < 9) c[i] = tx;
        end
        // a frame with a broken stop bit is dropped
        if (tx === 1'b1) got.push_back(c);
    end
endmodule
`default_nettype wire

/* File: test/mbws_slave_assertions.sv */
/*
 port assertions of the wake-up slave.
 assumes binding to mbws_slave.
*/
`timescale 1ns/1ns
`default_nettype none
module mbws_slave_assertions (
    input wire logic clock,
    input wire logic rst,
    input wire logic serial_port_tx,
    input wire logic line_driver_enable_n,
    input wire logic address_event,
    input wire logic poll_done,
    input wire logic poll_crc_ok
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    sequence judged_good;
        poll_done && poll_crc_ok;
    endsequence
    sequence judged_bad;
        poll_done && !poll_crc_ok;
    endsequence
    event_pulse_a: assert property (address_event |=> !address_event)
        else $error("long event");
    event_listen_a: assert property (address_event |-> line_driver_enable_n)
        else $error("event while driving");
    ok_done_a: assert property (poll_crc_ok |-> poll_done) else $error("ok alone");
    reply_enable_a: assert property (judged_good |-> ##[0:3] !line_driver_enable_n)
        else $error("no enable");
    enable_cause_a: assert property ($fell(line_driver_enable_n) |->
        poll_crc_ok || $past(poll_crc_ok) || $past(poll_crc_ok, 2)) else $error("bad enable");
    bad_silent_a: assert property (judged_bad |-> line_driver_enable_n [*8])
        else $error("enable after bad poll");
    release_stop_a: assert property ($rose(line_driver_enable_n) |-> $past(serial_port_tx))
        else $error("release in frame");
    quiet_line_a: assert property (line_driver_enable_n |-> serial_port_tx)
        else $error("tx while released");
endmodule
bind mbws_slave mbws_slave_assertions chk (.clock, .rst, .serial_port_tx,
    .line_driver_enable_n, .address_event, .poll_done, .poll_crc_ok);
`default_nettype wire

/* File: test/mbws_slave_tb.sv */
/*
 self-checking bench of the wake-up slave, queue models of poll and reply.
 assumes mbws_host and the checker bind compiled alongside.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mbws_regs.svh"
module mbws_slave_tb;
    import mbws_pkg::*;
    logic       clock = 0, rst = 1, resp_valid = 0, resp_last = 0, poll_ready = 0, okv;
    logic [7:0] module_address = 8'h5A, poll_data, pq [$], rq [$];
    mbws_len_t  poll_length = 8'h04;
    mbws_byte_t resp_data = 8'h00;
    logic       resp_ready, serial_port_rx, serial_port_tx, line_driver_enable_n;
    logic       address_event, poll_valid, poll_done, poll_crc_ok;
    int         ri, ev, dn, k, num_errors, cmp_count;
    always #5 clock = ~clock;
    mbws_slave DUT (.clock, .rst, .module_address, .poll_length, .resp_data, .resp_valid,
        .resp_ready, .resp_last, .serial_port_rx, .serial_port_tx, .line_driver_enable_n,
        .address_event, .poll_data, .poll_valid, .poll_ready, .poll_done, .poll_crc_ok);
    // released bus idles high through its fail-safe bias
    mbws_host host (.clock, .rx(serial_port_rx),
        .tx(line_driver_enable_n ? 1'b1 : serial_port_tx));
    task automatic chk(input logic [15:0] a, input logic [15:0] b);
        cmp_count++;
        if (a !== b) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, a, b);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clock) begin
        if (resp_valid && resp_ready) ri++;
        resp_valid <= ri < rq.size();
        resp_data  <= ri < rq.size() ? rq[ri] : 8'h00;
        resp_last  <= ri == rq.size() - 1;
        poll_ready <= $urandom % 4 != 0;
        if (address_event === 1'b1) ev++;
        if (poll_done === 1'b1) begin
            dn++;
            okv = poll_crc_ok;
        end
        if (poll_valid === 1'b1 && poll_ready) chk(poll_data, pq.size() ? pq.pop_front() : 0);
    end
    // address, two data bytes, crc high then low
    task automatic poll(input logic [7:0] a, input logic good);
        logic [15:0] c;
        logic [7:0]  b;
        c = `MBWS_CRC_INIT;
        host.send_char({1'b1, a});
        for (int i = 0; i < 4; i++) begin
            b = i == 2 ? c[15:8] : c[7:0] ^ {7'h00, !good};
            if (i < 2) begin
                b = 8'($urandom);
                c = c ^ {b, 8'h00};
                repeat (8) c = c[15] ? (c << 1) ^ `MBWS_CRC_POLY : c << 1;
            end
            if (a == module_address) pq.push_back(b);
            host.send_char({1'b0, b});
        end
    endtask
    initial begin
        void'($urandom(43878));
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        host.send_char(9'h03C);
        host.send_char(9'h0A5);
        chk(ev, 0);
        $display("test 1 done");
        poll(8'h5B, 1'b1);
        repeat (400) @(posedge clock);
        chk(ev, 1);
        chk(dn, 0);
        $display("test 2 done");
        for (int t = 3; t < 6; t++) begin
            host.got.delete();
            rq.delete();
            ri = 0;
            if (t != 4) repeat (3) rq.push_back(8'($urandom));
            poll(8'h5A, t != 4);
            for (k = 0; k < 1000 && dn < t - 2; k++) @(posedge clock);
            if (k == 1000) num_errors++;
            if (k == 1000) give_verdict();
            chk(okv, t != 4);
            chk(ev, t - 1);
            for (k = 0; k < 9000 && host.got.size() < rq.size(); k++) @(posedge clock);
            if (k == 9000) begin
                num_errors++;
                give_verdict();
            end
            // a rejected poll gets 3000 cycles, more than one frame time, to show any stray frame
            if (t == 4) repeat (3000) @(posedge clock);
            for (k = 0; k < 2500 && line_driver_enable_n !== 1'b1; k++) @(posedge clock);
            if (k == 2500) begin
                num_errors++;
                give_verdict();
            end
            chk(line_driver_enable_n, 1);
            chk(pq.size(), 0);
            chk(host.got.size(), rq.size());
            foreach (rq[i]) chk(host.got[i], {1'b0, rq[i]});
            $display("test %0d done", t);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
